//--- test/osc_model.sv
`timescale 1ns/1ps
// =====
// Resonators as tick pulses; a stopped one stays silent.
module osc_model #(
  parameter int FAST_DIV = 8,
  parameter int SLOW_DIV = 20
) (
  input wire logic core_clk,
  input wire logic fastEn,
  input wire logic slowEn,
  output logic fastTick,
  output logic slowTick
);
  int fastCnt = 0;
  int slowCnt = 0;
  initial begin
    fastTick = 1'b0;
    slowTick = 1'b0;
  end
  always @(posedge core_clk) begin
    fastCnt <= (fastCnt + 1) % FAST_DIV;
    slowCnt <= (slowCnt + 1) % SLOW_DIV;
    fastTick <= fastEn && fastCnt == 0;
    slowTick <= slowEn && slowCnt == 0;
  end
endmodule // osc_model

//--- test/system_clock_generator_tb.sv
`timescale 1ns/1ps
module system_clock_generator_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic pll_disable_pin = 1'b1;
  logic stopMode = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, lastOut;
  logic fastOscTick, slowOscTick, gearInputEn, sysClkEn, periphClkEn;
  logic prescalerInputEn, clock_out_pin, clockOutPinEn, pllRun;
  logic fastEn, slowEn, fastWeak, slowWeak;
  logic [5:0] evt;
  int ev [6] = '{default: 0};
  int base [6];
  int got [6];
  int failures = 0;
  int nTests = 0;
  int n, t0;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
    logic err;
  } row_s;
  row_s rows [8] = '{
    '{1'b0, 12'h000, 32'h0, 32'h1, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h3, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h3, 1'b0},
    '{1'b0, 12'h00c, 32'h0, 32'h3, 1'b0},
    '{1'b0, 12'h010, 32'h0, 32'h6, 1'b0},
    '{1'b1, 12'h010, 32'h0, 32'h6, 1'b0},
    '{1'b1, 12'h008, 32'h30, 32'h30, 1'b0},
    '{1'b1, 12'h014, 32'h0, 32'h0, 1'b1}
  };
  always #5 core_clk = ~core_clk;
  system_clock_generator dut (.core_clk(core_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fastOscTick(fastOscTick),
    .slowOscTick(slowOscTick), .pll_disable_pin(pll_disable_pin),
    .stopMode(stopMode), .gearInputEn(gearInputEn),
    .sysClkEn(sysClkEn), .periphClkEn(periphClkEn),
    .prescalerInputEn(prescalerInputEn), .clock_out_pin(clock_out_pin),
    .clockOutPinEn(clockOutPinEn), .pllRun(pllRun),
    .high_speed_osc_enable(fastEn), .low_speed_osc_enable(slowEn),
    .fast_osc_weak_drive(fastWeak), .slow_osc_weak_drive(slowWeak));
  osc_model osc (.core_clk(core_clk), .fastEn(fastEn), .slowEn(slowEn),
    .fastTick(fastOscTick), .slowTick(slowOscTick));
  // =====
  // Event counters; ratios are judged from differences of snapshots.
  assign evt = {clock_out_pin !== lastOut, prescalerInputEn, periphClkEn,
    sysClkEn, gearInputEn, fastOscTick};
  always @(posedge core_clk) begin
    lastOut <= clock_out_pin;
    for (int k = 0; k < 6; k++) ev[k] <= ev[k] + int'(evt[k] === 1'b1);
  end
  // =====
  // Tasks
  task automatic summarize();
    $display("Tests %0d failures %0d", nTests, failures);
    if (failures == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic near(input string what, input int a, input int b,
      input int tol);
    check(what, 32'(a - b <= tol && b - a <= tol), 32'h1);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      failures++;
      summarize();
    end
  endtask
  task automatic measure(input int cyc);
    base = ev;
    repeat (cyc) @(posedge core_clk);
    foreach (got[k]) got[k] = ev[k] - base[k];
  endtask
  task automatic doReset(input logic pin);
    rst_b <= 1'b0;
    pll_disable_pin <= pin;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("osc", {28'h0, fastEn, slowEn, fastWeak, slowWeak}, 32'h8);
    check("pllRun", 32'(pllRun), 32'(pin));
  endtask
  // =====
  // Main sequence
  initial begin
    doReset(1'b1);
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].addr, rows[i].data, rd, err);
      apb(1'b0, rows[i].addr, 32'h0, rd, err);
      check("err", 32'(err), 32'(rows[i].err));
      if (!rows[i].err) check("rdata", rd, rows[i].exp);
    end
    check("weak", {30'h0, fastWeak, slowWeak}, 32'h3);
    apb(1'b1, 12'h008, 32'h3, rd, err);
    $display("test registers done");
    // Lock-up time follows warm-up time, never shorter.
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, 12'h00c, 32'(s), rd, err);
      apb(1'b1, 12'h008, 32'(s), rd, err);
      // Software waits for the lock flag to clear before a new warm-up.
      n = 0;
      do begin
        apb(1'b0, 12'h010, 32'h0, rd, err);
        n++;
      end while (rd[1] !== 1'b0 && n < 100);
      if (n >= 100) begin
        failures++;
        summarize();
      end
      check("lockClr", {31'h0, rd[1]}, 32'h0);
      t0 = ev[0];
      apb(1'b1, 12'h000, 32'h101, rd, err);
      apb(1'b0, 12'h010, 32'h0, rd, err);
      check("busy", {31'h0, rd[0]}, 32'h1);
      n = 0;
      while (rd[0] === 1'b1 && n < 1000) begin
        apb(1'b0, 12'h010, 32'h0, rd, err);
        n++;
      end
      if (n >= 1000) begin
        failures++;
        summarize();
      end
      near("warmLen", ev[0] - t0, (s == 1) ? 256 : 4, 2);
      repeat (16) @(posedge core_clk);
      apb(1'b0, 12'h010, 32'h0, rd, err);
      check("status", rd, 32'h4);
    end
    measure(512);
    near("pll", got[1], 4 * got[0], 4);
    $display("test warmup and pll done");
    doReset(1'b0);
    measure(512);
    near("half", 2 * got[1], got[0], 2);
    apb(1'b1, 12'h004, 32'h23, rd, err);
    measure(512);
    near("full", got[1], got[0], 1);
    near("gear8", 8 * got[2], got[1], 8);
    near("presc4", 4 * got[4], got[2], 4);
    for (int g = 0; g < 3; g++) begin
      apb(1'b1, 12'h004, 32'h20 | 32'(g), rd, err);
      // A slow gear only switches at its next output pulse.
      repeat (80) @(posedge core_clk);
      measure(512);
      near("gear", got[2] << g, got[1], 4 << g);
    end
    apb(1'b1, 12'h004, 32'h30, rd, err);
    apb(1'b1, 12'h000, 32'h11, rd, err);
    measure(512);
    near("presc2", 2 * got[4], got[1], 2);
    $display("test gears done");
    apb(1'b1, 12'h00c, 32'h70, rd, err);
    repeat (2) @(posedge core_clk);
    check("pinEn", 32'(clockOutPinEn), 32'h1);
    measure(256);
    check("toggles", 32'(got[5] > 0), 32'h1);
    near("outRate", got[5], got[2], 2);
    apb(1'b1, 12'h008, 32'h2, rd, err);
    stopMode <= 1'b1;
    repeat (4) @(posedge core_clk);
    measure(256);
    check("stopped", 32'(got[5]), 32'h0);
    stopMode <= 1'b0;
    apb(1'b1, 12'h000, 32'h13, rd, err);
    apb(1'b1, 12'h00c, 32'h60, rd, err);
    repeat (40) @(posedge core_clk);
    measure(400);
    near("slowOut", got[5], 20, 2);
    apb(1'b1, 12'h00c, 32'h30, rd, err);
    repeat (2) @(posedge core_clk);
    check("pinOff", 32'(clockOutPinEn), 32'h0);
    $display("test clock out done");
    summarize();
  end
endmodule // system_clock_generator_tb

//--- verilog/clock_gen_consts.svh
`ifndef CLOCK_GEN_CONSTS_SVH
`define CLOCK_GEN_CONSTS_SVH
`define REG_CTRL0 12'h000
`define REG_CTRL1 12'h004
`define REG_CTRL2 12'h008
`define REG_CTRL3 12'h00c
`define REG_STATUS 12'h010
`define CTRL0_RST 32'h0000_0001
`define CTRL1_RST 32'h0000_0003
`define CTRL2_RST 32'h0000_0003
`define CTRL3_RST 32'h0000_0003
`define OSC_RST 4'h8
`define CFG_RST 13'h1f80
`define GEAR_SLOWEST 2'h3
`define GEAR_SETTLE 4'h4
`define PLL_MULT 2'h3
`define WARMUP_LEN0 17'h00004
`define WARMUP_LEN1 17'h00100
`define WARMUP_LEN2 17'h04000
`define WARMUP_LEN3 17'h10000
`endif

//--- verilog/clock_gen_pkg.sv
package clock_gen_pkg;
  typedef struct packed {
    logic fastOscEnable;
    logic slowOscEnable;
    logic fastOscWeak;
    logic slowOscWeak;
  } osc_ctrl_s;
  typedef struct packed {
    logic [1:0] gearSelect;
    logic [1:0] warmupSelect;
    logic [1:0] lockupSelect;
    logic [1:0] periphDivide;
    logic periphSource;
    logic oscDivideBypass;
    logic clockOutSelect;
    logic clockOutDir;
    logic clockOutFunc;
  } clk_cfg_s;
  typedef enum logic [1:0] {
    TmrIdle,
    TmrWarmup,
    TmrLockup
  } timer_state_e;
endpackage

//--- verilog/system_clock_generator.sv
// Behaviour
// - Reset gives fast osc on, slow osc off, gear slowest: gear input / 8.
// - PLL multiplies fast oscillator clock by four to make gear input.
// - PLL runs only if disable pin was High at reset release.
// - Bypassed PLL: divide bit resets 0 for half osc; 1 gives full osc.
// - Warm-up select picks 2^2, 2^8, 2^14 or 2^16 oscillator cycles.
// - Readable warm-up flag shows warm-up running and its completion.
// - Warm-up counter counts edges of the oscillator being settled.
// - Clock-out select: 0 slow clock, 1 system clock; STOP holds constant.
// - Pin outputs clock only when direction and function bits are 1.
// - Drive bits: 1 weak, 0 normal, both reset to 0.
// - Peripheral clock source gear out or in, divide 4, 2 or 1.
// - One shared timer; lock-up time default 2^16 cycles.
// - Lock counter starts with fast warm-up; flag 1 until lock.
// - Lock flag is undefined when PLL disable pin is Low.
// - Gear writes take effect only after several cycles.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "clock_gen_consts.svh"
module system_clock_generator
  import clock_gen_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fastOscTick,
  input wire logic slowOscTick,
  input wire logic pll_disable_pin,
  input wire logic stopMode,
  output logic gearInputEn,
  output logic sysClkEn,
  output logic periphClkEn,
  output logic prescalerInputEn,
  output logic clock_out_pin,
  output logic clockOutPinEn,
  output logic pllRun,
  output logic high_speed_osc_enable,
  output logic low_speed_osc_enable,
  output logic fast_osc_weak_drive,
  output logic slow_osc_weak_drive
);
  // ==========================================================
  // Register bus
  // ==========================================================
  osc_ctrl_s osc_q, osc_d;
  clk_cfg_s cfg_q, cfg_d;
  logic startWarm;
  logic wr;
  logic [16:0] cnt_q, cnt_d;
  timer_state_e tmr_q, tmr_d;
  logic warmBusy_q, warmBusy_d;
  logic lockPend_q, lockPend_d;
  logic useFast_q, useFast_d;
  logic pllOn_q, pllOn_d;
  logic strapDone_q, strapDone_d;

  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr > `REG_STATUS);

  always_comb begin
    osc_d = osc_q;
    cfg_d = cfg_q;
    startWarm = 1'b0;
    if (wr) begin
      unique case (paddr)
        `REG_CTRL0: begin
          osc_d.fastOscEnable = pwdata[0];
          osc_d.slowOscEnable = pwdata[1];
          cfg_d.periphDivide = pwdata[5:4];
          startWarm = pwdata[8];
        end
        `REG_CTRL1: begin
          cfg_d.gearSelect = pwdata[1:0];
          cfg_d.periphSource = pwdata[4];
          cfg_d.oscDivideBypass = pwdata[5];
        end
        `REG_CTRL2: begin
          cfg_d.warmupSelect = pwdata[1:0];
          osc_d.fastOscWeak = pwdata[4];
          osc_d.slowOscWeak = pwdata[5];
        end
        `REG_CTRL3: begin
          cfg_d.lockupSelect = pwdata[1:0];
          cfg_d.clockOutSelect = pwdata[4];
          cfg_d.clockOutDir = pwdata[5];
          cfg_d.clockOutFunc = pwdata[6];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `REG_CTRL0: prdata = {26'h0, cfg_q.periphDivide, 2'h0,
                            osc_q.slowOscEnable, osc_q.fastOscEnable};
      `REG_CTRL1: prdata = {26'h0, cfg_q.oscDivideBypass,
                            cfg_q.periphSource, 2'h0, cfg_q.gearSelect};
      `REG_CTRL2: prdata = {26'h0, osc_q.slowOscWeak, osc_q.fastOscWeak,
                            2'h0, cfg_q.warmupSelect};
      `REG_CTRL3: prdata = {25'h0, cfg_q.clockOutFunc, cfg_q.clockOutDir,
                            cfg_q.clockOutSelect, 2'h0, cfg_q.lockupSelect};
      // Lock flag reads as plain state; it carries no meaning with PLL off.
      `REG_STATUS: prdata = {29'h0, pllOn_q, lockPend_q, warmBusy_q};
      default: prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_q <= osc_ctrl_s'(`OSC_RST);
      cfg_q <= clk_cfg_s'(`CFG_RST);
    end else begin
      osc_q <= osc_d;
      cfg_q <= cfg_d;
    end
  end

  // ==========================================================
  // PLL strap and shared warm-up / lock-up timer
  // ==========================================================
  function automatic logic [16:0] span(input logic [1:0] sel);
    unique case (sel)
      2'h0: span = `WARMUP_LEN0;
      2'h1: span = `WARMUP_LEN1;
      2'h2: span = `WARMUP_LEN2;
      2'h3: span = `WARMUP_LEN3;
    endcase
  endfunction

  logic oscTick;
  assign oscTick = useFast_q ? fastOscTick : slowOscTick;

  always_comb begin
    cnt_d = cnt_q;
    tmr_d = tmr_q;
    warmBusy_d = warmBusy_q;
    lockPend_d = lockPend_q;
    pllOn_d = pllOn_q;
    strapDone_d = 1'b1;
    useFast_d = useFast_q;
    if (!strapDone_q) begin
      pllOn_d = pll_disable_pin;
      tmr_d = pll_disable_pin ? TmrLockup : TmrIdle;
    end
    if (startWarm) begin
      useFast_d = osc_q.fastOscEnable;
      cnt_d = 17'h0;
      tmr_d = TmrWarmup;
      warmBusy_d = 1'b1;
      lockPend_d = osc_q.fastOscEnable & pllOn_q;
    end else if (tmr_q != TmrIdle && oscTick) begin
      cnt_d = cnt_q + 17'h1;
      if (tmr_q == TmrWarmup && cnt_d >= span(cfg_q.warmupSelect)) begin
        warmBusy_d = 1'b0;
        tmr_d = lockPend_q ? TmrLockup : TmrIdle;
      end
      if (cnt_d >= span(cfg_q.lockupSelect)) begin
        lockPend_d = 1'b0;
        if (tmr_q == TmrLockup) begin
          tmr_d = TmrIdle;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 17'h0;
      tmr_q <= TmrIdle;
      warmBusy_q <= 1'b0;
      lockPend_q <= 1'b1;
      pllOn_q <= 1'b0;
      strapDone_q <= 1'b0;
      useFast_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      tmr_q <= tmr_d;
      warmBusy_q <= warmBusy_d;
      lockPend_q <= lockPend_d;
      pllOn_q <= pllOn_d;
      strapDone_q <= strapDone_d;
      useFast_q <= useFast_d;
    end
  end

  // ==========================================================
  // Clock tree enables
  // ==========================================================
  // Each derived clock except the toggled clock_out_pin level is a one-cycle enable pulse on core_clk, so a
  // ratio change can only ever land between whole pulses.
  logic [1:0] pllPh_q, pllPh_d;
  logic halfPh_q, halfPh_d;
  logic gearIn;
  logic [2:0] gearCnt_q, gearCnt_d;
  logic [1:0] gearAct_q, gearAct_d;
  logic [3:0] settle_q, settle_d;
  logic [2:0] gearMask;
  logic gearOut;
  logic [1:0] perCnt_q, perCnt_d;
  logic perSrc;
  logic prescIn;
  logic sysTog_q, sysTog_d;
  logic slowTog_q, slowTog_d;
  logic outVal_q, outVal_d;
  logic outSel_q, outSel_d;

  always_comb begin
    pllPh_d = (pllPh_q != 2'h0) ? pllPh_q - 2'h1 : pllPh_q;
    halfPh_d = halfPh_q;
    if (fastOscTick) begin
      pllPh_d = `PLL_MULT;
      halfPh_d = ~halfPh_q;
    end
    if (pllOn_q) begin
      gearIn = fastOscTick | (pllPh_q != 2'h0);
    end else if (cfg_q.oscDivideBypass) begin
      gearIn = fastOscTick;
    end else begin
      gearIn = fastOscTick & halfPh_q;
    end
  end

  always_comb begin
    unique case (gearAct_q)
      2'h0: gearMask = 3'h0;
      2'h1: gearMask = 3'h1;
      2'h2: gearMask = 3'h3;
      2'h3: gearMask = 3'h7;
    endcase
    gearOut = gearIn & ((gearCnt_q & gearMask) == gearMask);
    gearCnt_d = gearCnt_q;
    gearAct_d = gearAct_q;
    settle_d = settle_q;
    if (gearAct_q != cfg_q.gearSelect) begin
      settle_d = (settle_q < `GEAR_SETTLE) ? settle_q + 4'h1 : settle_q;
      if (settle_q >= `GEAR_SETTLE && gearOut) begin
        gearAct_d = cfg_q.gearSelect;
        gearCnt_d = 3'h0;
        settle_d = 4'h0;
      end
    end else begin
      settle_d = 4'h0;
    end
    if (gearIn && gearAct_d == gearAct_q) begin
      gearCnt_d = gearOut ? 3'h0 : gearCnt_q + 3'h1;
    end
  end

  always_comb begin
    perSrc = cfg_q.periphSource ? gearIn : gearOut;
    perCnt_d = perCnt_q;
    if (perSrc) begin
      perCnt_d = perCnt_q + 2'h1;
    end
    unique case (cfg_q.periphDivide)
      2'h0: prescIn = perSrc & (perCnt_q == 2'h3);
      2'h1: prescIn = perSrc & perCnt_q[0];
      default: prescIn = perSrc;
    endcase
  end

  always_comb begin
    sysTog_d = gearOut ? ~sysTog_q : sysTog_q;
    slowTog_d = slowOscTick ? ~slowTog_q : slowTog_q;
    outSel_d = outSel_q;
    if (sysTog_q == slowTog_q) begin
      outSel_d = cfg_q.clockOutSelect;
    end
    outVal_d = outVal_q;
    if (!stopMode) begin
      outVal_d = outSel_q ? sysTog_q : slowTog_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pllPh_q <= 2'h0;
      halfPh_q <= 1'b0;
      gearCnt_q <= 3'h0;
      gearAct_q <= `GEAR_SLOWEST;
      settle_q <= 4'h0;
      perCnt_q <= 2'h0;
      sysTog_q <= 1'b0;
      slowTog_q <= 1'b0;
      outVal_q <= 1'b0;
      outSel_q <= 1'b0;
    end else begin
      pllPh_q <= pllPh_d;
      halfPh_q <= halfPh_d;
      gearCnt_q <= gearCnt_d;
      gearAct_q <= gearAct_d;
      settle_q <= settle_d;
      perCnt_q <= perCnt_d;
      sysTog_q <= sysTog_d;
      slowTog_q <= slowTog_d;
      outVal_q <= outVal_d;
      outSel_q <= outSel_d;
    end
  end

  assign gearInputEn = gearIn;
  assign sysClkEn = gearOut;
  assign periphClkEn = perSrc;
  assign prescalerInputEn = prescIn;
  assign clockOutPinEn = cfg_q.clockOutDir & cfg_q.clockOutFunc;
  assign clock_out_pin = clockOutPinEn & outVal_q;
  assign pllRun = pllOn_q;
  assign high_speed_osc_enable = osc_q.fastOscEnable;
  assign low_speed_osc_enable = osc_q.slowOscEnable;
  assign fast_osc_weak_drive = osc_q.fastOscWeak;
  assign slow_osc_weak_drive = osc_q.slowOscWeak;

  // ==========================================================
  // Checks
  // ==========================================================
  sequence warmStart_s;
    wr && paddr == `REG_CTRL0 && pwdata[8];
  endsequence

  gear_reset_slow_a: assert property (@(posedge core_clk)
    $rose(rst_b) |-> gearAct_q == 2'h3)
    else $error("gear not slowest after reset");
  warm_flag_set_a: assert property (@(posedge core_clk)
    disable iff (!rst_b) warmStart_s |=> warmBusy_q)
    else $error("warm flag not set on start");
  gear_hold_a: assert property (@(posedge core_clk)
    disable iff (!rst_b) $changed(cfg_q.gearSelect) |=> $stable(gearAct_q))
    else $error("gear switched at once");
  gear_boundary_a: assert property (@(posedge core_clk)
    disable iff (!rst_b) $changed(gearAct_q) |-> $past(gearOut))
    else $error("gear changed off boundary");
  stop_hold_a: assert property (@(posedge core_clk)
    disable iff (!rst_b) stopMode |=> $stable(outVal_q))
    else $error("clock out moved in stop");
  pin_gate_a: assert property (@(posedge core_clk)
    disable iff (!rst_b) !clockOutPinEn |-> !clock_out_pin)
    else $error("pin driven while not clock out");
  pll_full_a: assert property (@(posedge core_clk)
    disable iff (!rst_b) pllOn_q && fastOscTick |-> gearIn[*4])
    else $error("pll gear input missing");
  half_rate_a: assert property (@(posedge core_clk)
    disable iff (!rst_b) gearIn && !pllOn_q && !cfg_q.oscDivideBypass
    |-> fastOscTick && halfPh_q)
    else $error("osc half rate wrong");
  warm_osc_a: assert property (@(posedge core_clk)
    disable iff (!rst_b) !oscTick && !startWarm |=> $stable(cnt_q))
    else $error("warm counter moved without osc");
endmodule // system_clock_generator
